// *** mcd_pkg.sv ***
// Package of constants, register map and types for the CSMA/CD line logic.
package mcd_pkg;
    // Register byte addresses.
    localparam logic [7:0] ADDR_IFS = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_TXDATA = 8'h0C;
    localparam logic [7:0] ADDR_RXDATA = 8'h10;
    // Control register fields.
    localparam int CTRL_CD_MODE = 0;
    localparam int CTRL_EXT_CLK = 1;
    localparam int CTRL_BK_LO = 2;
    localparam int CTRL_BK_HI = 3;
    localparam int CTRL_DET = 4;
    localparam int CTRL_RX_EN = 5;
    localparam int CTRL_TX_EN = 6;
    // Status register fields.
    localparam int ST_LINE_IDLE = 0;
    localparam int ST_RX_ABORT = 1;
    localparam int ST_TX_ERR = 2;
    localparam int ST_COLL = 3;
    localparam int ST_DET_START = 4;
    localparam int ST_TX_BUSY = 5;
    localparam int ST_RX_VALID = 6;
    localparam int ST_JAM = 7;
    localparam int ST_CNT_LO = 8;
    // Reset values, timing, collision limit and bus response codes.
    localparam logic [7:0] IFS_RESET = 8'h00;
    localparam logic [8:0] IFS_ZERO_BITS = 9'h100;
    localparam int SAMPLES_PER_BIT = 8;
    localparam int MIN_PULSE = 3;
    localparam int EDGE_FALL_LIMIT = 5;
    localparam int CENTRE_FALL_LIMIT = 6;
    localparam int IDLE_SAMPLES = 12;
    localparam logic [3:0] MAX_COLL = 4'h8;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Transmit sequencer states.
    typedef enum logic [4:0] {
        MCD_TX_IDLE = 5'h01,
        MCD_TX_DEFER = 5'h02,
        MCD_TX_SEND = 5'h04,
        MCD_TX_JAM = 5'h08,
        MCD_TX_WAIT = 5'h10
    } mcd_tx_state_t;
endpackage

// *** mcd_rx_decode.sv ***
// Manchester receive decoder with collision and line idle detection.
module mcd_rx_decode import mcd_pkg::*; (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // Sample strobe and synchronised line level.
    input wire logic sample_tick,
    input wire logic line_level,
    // Results.
    output logic bit_valid,
    output logic bit_value,
    output logic collision,
    output logic line_idle,
    output logic activity
);
    typedef struct packed {
        logic level;
        logic [4:0] run;
        logic fell_at_centre;
        logic bit_valid;
        logic bit_value;
        logic collision;
        logic line_idle;
    } mcd_dec_t;
    mcd_dec_t cur, nxt;

    // Each sample either extends the current run or closes it at a transition.
    always_comb begin
        nxt = cur;
        nxt.bit_valid = 1'b0;
        nxt.collision = 1'b0;
        if (sample_tick) begin
            if (line_level != cur.level) begin
                nxt.level = line_level;
                nxt.run = 5'h01;
                if (cur.run < 5'(MIN_PULSE) && !cur.line_idle) begin
                    nxt.collision = 1'b1;
                end else if (line_level) begin
                    nxt.bit_valid = 1'b1;
                    nxt.bit_value = 1'b1;
                end else if (cur.run > 5'(SAMPLES_PER_BIT + 2) && cur.run < 5'(IDLE_SAMPLES)) begin
                    nxt.collision = 1'b1;
                end else begin
                    // A long high run means the fall sits at a cell centre.
                    nxt.fell_at_centre = cur.run > 5'(SAMPLES_PER_BIT / 2 + 1);
                    nxt.bit_valid = cur.run > 5'(SAMPLES_PER_BIT / 2 + 1);
                    nxt.bit_value = 1'b0;
                    nxt.line_idle = 1'b0;
                end
            end else begin
                if (cur.run != 5'h1F) begin
                    nxt.run = cur.run + 5'h01;
                end
                if (!cur.level && !cur.fell_at_centre && cur.run == 5'(EDGE_FALL_LIMIT + 3)) begin
                    nxt.collision = 1'b1;
                end
                if (!cur.level && cur.fell_at_centre && cur.run == 5'(CENTRE_FALL_LIMIT + 6)) begin
                    nxt.collision = 1'b1;
                end
                if (cur.level && cur.run == 5'(IDLE_SAMPLES)) begin
                    nxt.line_idle = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cur <= '{level: 1'b1, run: 5'h1F, fell_at_centre: 1'b0, bit_valid: 1'b0,
                     bit_value: 1'b0, collision: 1'b0, line_idle: 1'b1};
        end else begin
            cur <= nxt;
        end
    end

    assign bit_valid = cur.bit_valid;
    assign bit_value = cur.bit_value;
    assign collision = cur.collision;
    assign line_idle = cur.line_idle;
    assign activity = !cur.line_idle;
endmodule // mcd_rx_decode

// *** mcd_line.sv ***
// CSMA/CD line logic: interframe space, Manchester transmit, collision response.
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
module mcd_line import mcd_pkg::*; #(
    parameter int BIT_CLOCKS = 8
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // AXI4-Lite write address and data.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial line.
    input wire logic serial_receive_pin,
    output logic serial_transmit_pin
);
    import mcd_pkg::*;

    localparam int BIT_W = $clog2(BIT_CLOCKS + 1);
    localparam int SMP_CLOCKS = (BIT_CLOCKS / SAMPLES_PER_BIT < 1) ? 1 : BIT_CLOCKS / SAMPLES_PER_BIT;

    typedef struct packed {
        logic [1:0] pin_sync;
        logic awv;
        logic [7:0] awaddr;
        logic wv;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [6:0] ifs_hi;
        logic [6:0] ctrl;
        logic line_idle_flag;
        logic receive_abort_flag;
        logic transmit_collision_error_flag;
        logic coll_seen;
        logic det_start;
        logic [3:0] coll_count;
        logic [BIT_W-1:0] bit_cnt;
        logic [7:0] smp_cnt;
        logic [8:0] ifs_cnt;
        logic ifs_half;
        logic ifs_done;
        mcd_tx_state_t tx_state;
        logic [7:0] tx_byte;
        logic tx_pending;
        logic tx_sent_byte;
        logic [2:0] tx_bit;
        logic [4:0] jam_cnt;
        logic tx_pin;
        logic [7:0] rx_shift;
        logic [2:0] rx_bits;
        logic [7:0] rx_data;
        logic rx_valid;
        logic rx_byte_seen;
    } mcd_state_t;
    mcd_state_t cur, nxt;

    logic smp_tick;
    logic dec_valid, dec_value, dec_coll, dec_idle, dec_act;
    logic bit_tick, half_tick;
    logic [7:0] wr_ifs;

    // Space length with the zero case mapped to the long interval.
    function automatic logic [8:0] ifs_bits(input logic [6:0] hi);
        ifs_bits = (hi == 7'h00) ? IFS_ZERO_BITS : {1'b0, hi, 1'b0};
    endfunction

    // Merge a write word into a narrow field by byte lane zero.
    function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
        lane0 = s[0] ? d[7:0] : old;
    endfunction

    assign smp_tick = cur.smp_cnt == 8'(SMP_CLOCKS - 1);
    assign bit_tick = cur.bit_cnt == BIT_W'(BIT_CLOCKS - 1);
    assign half_tick = cur.bit_cnt == BIT_W'(BIT_CLOCKS / 2 - 1);

    mcd_rx_decode u_dec (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .sample_tick(smp_tick),
        .line_level(cur.pin_sync[1]),
        .bit_valid(dec_valid),
        .bit_value(dec_value),
        .collision(dec_coll),
        .line_idle(dec_idle),
        .activity(dec_act)
    );

    // Bus slave, timing, sequencer and collision response in one next-state block.
    always_comb begin
        nxt = cur;
        wr_ifs = 8'h00;
        nxt.pin_sync = {cur.pin_sync[0], serial_receive_pin};
        nxt.smp_cnt = smp_tick ? 8'h00 : cur.smp_cnt + 8'h01;
        nxt.bit_cnt = bit_tick ? '0 : cur.bit_cnt + BIT_W'(1);
        nxt.det_start = 1'b0;

        // Receive bytes assemble LSB first.
        if (dec_valid && cur.ctrl[CTRL_RX_EN]) begin
            nxt.rx_shift = {dec_value, cur.rx_shift[7:1]};
            nxt.rx_bits = cur.rx_bits + 3'h1;
            if (cur.rx_bits == 3'h7) begin
                nxt.rx_data = {dec_value, cur.rx_shift[7:1]};
                nxt.rx_valid = 1'b1;
                nxt.rx_byte_seen = 1'b1;
            end
        end
        if (dec_idle) begin
            nxt.rx_bits = 3'h0;
            nxt.rx_byte_seen = 1'b0;
            nxt.line_idle_flag = 1'b1;
        end

        // Space timer: the LSB marks the first half; busy line restarts it.
        if (dec_act && (cur.tx_state == MCD_TX_IDLE || cur.tx_state == MCD_TX_DEFER)) begin
            if (!cur.ifs_half || cur.ifs_cnt == 9'h000 || !cur.ifs_done) begin
                nxt.ifs_cnt = ifs_bits(cur.ifs_hi);
                nxt.ifs_half = 1'b1;
                nxt.ifs_done = 1'b0;
            end
        end
        if (!cur.ifs_done && bit_tick && !(dec_act && cur.ifs_cnt == ifs_bits(cur.ifs_hi))) begin
            if (cur.ifs_cnt <= 9'h001) begin
                nxt.ifs_done = 1'b1;
                nxt.ifs_cnt = 9'h000;
            end else begin
                nxt.ifs_cnt = cur.ifs_cnt - 9'h001;
            end
            nxt.ifs_half = cur.ifs_cnt > (ifs_bits(cur.ifs_hi) >> 1);
        end
        // Normal random backoff restarts the interval on activity in the first half.
        if (dec_act && cur.ifs_half && !cur.ifs_done && cur.ctrl[CTRL_BK_HI:CTRL_BK_LO] == 2'b00
            && !cur.ctrl[CTRL_DET]) begin
            nxt.ifs_cnt = ifs_bits(cur.ifs_hi);
        end

        // Transmit sequencer, Manchester cells with a mid-bit transition.
        unique case (cur.tx_state)
            MCD_TX_IDLE: begin
                nxt.tx_pin = 1'b1;
                if (cur.tx_pending && cur.ctrl[CTRL_TX_EN]) begin
                    nxt.tx_state = MCD_TX_DEFER;
                end
            end
            MCD_TX_DEFER: begin
                if (cur.ifs_done && bit_tick) begin
                    nxt.tx_state = MCD_TX_SEND;
                    nxt.tx_bit = 3'h0;
                    // The first half cell carries the inverse so the centre edge encodes bit zero.
                    nxt.tx_pin = !cur.tx_byte[0];
                end
            end
            MCD_TX_SEND: begin
                if (half_tick) begin
                    nxt.tx_pin = cur.tx_byte[cur.tx_bit];
                end
                if (bit_tick) begin
                    nxt.tx_sent_byte = cur.tx_sent_byte | (cur.tx_bit == 3'h7);
                    nxt.tx_bit = cur.tx_bit + 3'h1;
                    if (cur.tx_bit == 3'h7) begin
                        nxt.tx_pending = 1'b0;
                        nxt.tx_state = MCD_TX_IDLE;
                    end else begin
                        nxt.tx_pin = !cur.tx_byte[cur.tx_bit + 3'h1];
                    end
                end
            end
            MCD_TX_JAM: begin
                nxt.tx_pin = 1'b0;
                if (bit_tick) begin
                    nxt.jam_cnt = cur.jam_cnt - 5'h01;
                    if (cur.jam_cnt == 5'h00) begin
                        nxt.tx_state = MCD_TX_WAIT;
                    end
                end
            end
            MCD_TX_WAIT: begin
                nxt.tx_pin = 1'b1;
                if (dec_idle) begin
                    nxt.tx_state = (cur.tx_pending && cur.ctrl[CTRL_TX_EN]) ? MCD_TX_DEFER : MCD_TX_IDLE;
                end
            end
        endcase

        // Collision response selected from what the channel is doing.
        if (dec_coll && cur.ctrl[CTRL_CD_MODE] && !cur.ctrl[CTRL_EXT_CLK]) begin
            nxt.coll_seen = 1'b1;
            if (cur.tx_state == MCD_TX_SEND) begin
                nxt.tx_state = MCD_TX_JAM;
                nxt.jam_cnt = 5'h0F;
                if (cur.tx_sent_byte || cur.coll_count >= MAX_COLL) begin
                    nxt.transmit_collision_error_flag = 1'b1;
                    nxt.ctrl[CTRL_TX_EN] = 1'b0;
                    nxt.tx_pending = 1'b0;
                end else begin
                    nxt.coll_count = cur.coll_count + 4'h1;
                end
            end else begin
                nxt.det_start = cur.ctrl[CTRL_DET];
                nxt.rx_bits = 3'h0;
                if (cur.rx_byte_seen) begin
                    nxt.receive_abort_flag = 1'b1;
                    nxt.ctrl[CTRL_RX_EN] = 1'b0;
                    nxt.rx_byte_seen = 1'b0;
                end
            end
        end

        // Write channel: address and data taken in either order, answered together.
        if (s_axi_awvalid && !cur.awv && !cur.bvalid) begin
            nxt.awv = 1'b1;
            nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !cur.wv && !cur.bvalid) begin
            nxt.wv = 1'b1;
            nxt.wdata = s_axi_wdata;
            nxt.wstrb = s_axi_wstrb;
        end
        if (cur.awv && cur.wv) begin
            nxt.awv = 1'b0;
            nxt.wv = 1'b0;
            nxt.bvalid = 1'b1;
            nxt.bresp = RESP_OK;
            unique case ({cur.awaddr[7:2], 2'b00})
                ADDR_IFS: begin
                    wr_ifs = lane0({cur.ifs_hi, 1'b0}, cur.wdata, cur.wstrb);
                    nxt.ifs_hi = wr_ifs[7:1];
                end
                ADDR_CTRL: begin
                    wr_ifs = lane0({1'b0, cur.ctrl}, cur.wdata, cur.wstrb);
                    nxt.ctrl = wr_ifs[6:0];
                end
                ADDR_STATUS: begin
                    // Write one to clear the flags, any lane one write clears the count; a fresh event this cycle keeps its bit.
                    if (cur.wstrb[0] && cur.wdata[ST_LINE_IDLE] && !dec_idle) nxt.line_idle_flag = 1'b0;
                    if (cur.wstrb[0] && cur.wdata[ST_RX_ABORT] && nxt.receive_abort_flag == cur.receive_abort_flag)
                        nxt.receive_abort_flag = 1'b0;
                    if (cur.wstrb[0] && cur.wdata[ST_TX_ERR] && nxt.transmit_collision_error_flag ==
                        cur.transmit_collision_error_flag) nxt.transmit_collision_error_flag = 1'b0;
                    if (cur.wstrb[0] && cur.wdata[ST_COLL] && !dec_coll) nxt.coll_seen = 1'b0;
                    if (cur.wstrb[1]) nxt.coll_count = 4'h0;
                end
                ADDR_TXDATA: begin
                    if (cur.tx_pending) begin
                        nxt.bresp = RESP_SLVERR;
                    end else if (cur.wstrb[0]) begin
                        nxt.tx_byte = cur.wdata[7:0];
                        nxt.tx_pending = 1'b1;
                        nxt.tx_sent_byte = 1'b0;
                    end
                end
                default: nxt.bresp = RESP_DECERR;
            endcase
        end
        if (cur.bvalid && s_axi_bready) begin
            nxt.bvalid = 1'b0;
        end

        // Read channel: one cycle to answer, data held until taken.
        if (s_axi_arvalid && !cur.rvalid) begin
            nxt.rvalid = 1'b1;
            nxt.rresp = RESP_OK;
            nxt.rdata = 32'h0000_0000;
            unique case ({s_axi_araddr[7:2], 2'b00})
                ADDR_IFS: nxt.rdata = {24'h000000, cur.ifs_hi, cur.ifs_half};
                ADDR_CTRL: nxt.rdata = {25'h0000000, cur.ctrl};
                ADDR_STATUS: nxt.rdata = {20'h00000, cur.coll_count, cur.tx_state == MCD_TX_JAM,
                    cur.rx_valid, cur.tx_state != MCD_TX_IDLE, cur.det_start, cur.coll_seen,
                    cur.transmit_collision_error_flag, cur.receive_abort_flag, cur.line_idle_flag};
                ADDR_TXDATA: nxt.rdata = {24'h000000, cur.tx_byte};
                ADDR_RXDATA: begin
                    nxt.rdata = {23'h000000, cur.rx_valid, cur.rx_data};
                    nxt.rx_valid = 1'b0;
                end
                default: nxt.rresp = RESP_DECERR;
            endcase
        end
        if (cur.rvalid && s_axi_rready) begin
            nxt.rvalid = 1'b0;
        end
    end

    // State register; the space register resets to zero so the first start waits the long interval.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cur <= '0;
            cur.pin_sync <= 2'b11;
            cur.ifs_hi <= IFS_RESET[7:1];
            cur.ifs_cnt <= IFS_ZERO_BITS;
            cur.ifs_half <= 1'b1;
            cur.tx_state <= MCD_TX_IDLE;
            cur.tx_pin <= 1'b1;
            cur.line_idle_flag <= 1'b1;
        end else begin
            cur <= nxt;
        end
    end

    assign s_axi_awready = !cur.awv && !cur.bvalid;
    assign s_axi_wready = !cur.wv && !cur.bvalid;
    assign s_axi_bvalid = cur.bvalid;
    assign s_axi_bresp = cur.bresp;
    assign s_axi_arready = !cur.rvalid;
    assign s_axi_rvalid = cur.rvalid;
    assign s_axi_rdata = cur.rdata;
    assign s_axi_rresp = cur.rresp;
    assign serial_transmit_pin = cur.tx_pin;
endmodule // mcd_line

// *** mcd_line_partner.sv ***
// Model of another station on the shared line, wired-AND with a pull-up.
module mcd_line_partner (
    // Clock.
    input wire logic ref_clk,
    // Shared line.
    input wire logic station_tx,
    output logic line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drive = 1'b1;
    // A released line returns to the pull-up level, never a stale value.
    assign line = station_tx & drive;
    // Holds one level for n clocks.
    task automatic half(input logic v, input int n);
        drive <= v;
        repeat (n) @(posedge ref_clk);
    endtask
    // Sends one byte as Manchester cells of eight clocks.
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            half(~b[i], 4);
            half(b[i], 4);
        end
        drive <= 1'b1;
    endtask
    // A two-sample pulse, too short to be a valid half cell.
    task automatic pulse();
        half(1'b0, 2);
        drive <= 1'b1;
    endtask
endmodule // mcd_line_partner

// *** mcd_line_monitor.sv ***
// Checker of bus handshakes and line timing at the ports of mcd_line.
module mcd_line_monitor #(
    parameter int BIT_CLOCKS = 8
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // Write channels.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels.
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Line.
    input wire logic serial_transmit_pin
);
    localparam int LIM = 255 * BIT_CLOCKS;
    logic [15:0] since;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Counts cycles since reset release, saturating so it never wraps.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) since <= 16'h0;
        else if (since != 16'hFFFF) since <= since + 16'h1;
    end
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_B_AFTER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    AST_R_AFTER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");
    AST_W_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during answer");
    AST_BRESP_CODE: assert property (s_axi_bvalid |-> s_axi_bresp != 2'h1)
        else $error("write response code unused");
    AST_FIRST_TX: assert property (since < LIM |-> serial_transmit_pin)
        else $error("transmit before the reset interframe space");
    AST_HALF_CELL: assert property ($fell(serial_transmit_pin) |-> !serial_transmit_pin [*3])
        else $error("transmit low level too short");
    // Main scenarios.
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property ($fell(serial_transmit_pin));
endmodule // mcd_line_monitor
bind mcd_line mcd_line_monitor #(.BIT_CLOCKS(BIT_CLOCKS)) mcd_line_monitor_inst (.ref_clk, .reset_n,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .serial_transmit_pin);

// *** mcd_line_tb.sv ***
// Self-checking bench of mcd_line: registers, deference, coding, collisions.
module mcd_line_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mcd_pkg::*;
    typedef struct packed { logic [7:0] w; logic [7:0] e; } mcd_row_t;
    localparam logic [31:0] CTL = (32'h1 << CTRL_CD_MODE) | (32'h1 << CTRL_RX_EN) | (32'h1 << CTRL_TX_EN);
    mcd_row_t rows [3] = '{'{8'hFF, 8'hFE}, '{8'h10, 8'h10}, '{8'h03, 8'h02}};
    logic ref_clk = 1'b0, reset_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic serial_receive_pin, serial_transmit_pin;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int error_cnt = 0, checked = 0, cyc = 0, t, p;
    mcd_line mcd_line_inst (.ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .serial_receive_pin, .serial_transmit_pin);
    mcd_line_partner mcd_line_partner_inst (.ref_clk, .station_tx(serial_transmit_pin), .line(serial_receive_pin));
    // Clock and a cycle count since reset release.
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= reset_n ? cyc + 1 : 0;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // Handshakes are looked at on the falling edge, where they equal what the next rising edge samples.
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        logic ta, tw, tb;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge ref_clk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge ref_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (tb !== 1'b1);
        s_axi_bready <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        logic ta, tb;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge ref_clk);
            ta = s_axi_arready;
            tb = s_axi_rvalid;
            v = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge ref_clk);
            if (ta) s_axi_arvalid <= 1'b0;
        end while (tb !== 1'b1);
        s_axi_rready <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Waits for a frame start and decodes one byte from the second half of each cell.
    task automatic tx_byte(output int ts, output logic [31:0] b);
        b = 32'h0;
        do @(negedge ref_clk); while (serial_transmit_pin !== 1'b0);
        ts = cyc;
        repeat (5) @(negedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            b[i] = serial_transmit_pin;
            repeat (8) @(negedge ref_clk);
        end
        @(posedge ref_clk);
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Watchdog sized well above the whole sequence.
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        rd(ADDR_IFS, d, r);
        chk("ifs reset", {24'h0, IFS_RESET}, d & 32'hFE);
        rd(8'h20, d, r);
        chk("unmapped resp", {30'h0, RESP_DECERR}, {30'h0, r});
        wr(ADDR_CTRL, CTL, r);
        wr(ADDR_TXDATA, 32'hA5, r);
        chk("tx resp", {30'h0, RESP_OK}, {30'h0, r});
        tx_byte(t, d);
        chk("first tx late", 32'h1, 32'(t >= 32'(IFS_ZERO_BITS) * 8 - 8));
        chk("tx byte", 32'hA5, d);
        // Software-owned bits of the space length; the low bit belongs to the device.
        foreach (rows[i]) begin
            wr(ADDR_IFS, {24'h0, rows[i].w}, r);
            rd(ADDR_IFS, d, r);
            chk("ifs bits", {24'h0, rows[i].e}, d & 32'hFE);
        end
        // Deference behind another station's frame, then one space of four bits.
        wr(ADDR_IFS, 32'h04, r);
        fork
            mcd_line_partner_inst.send_byte(8'h3C);
            begin
                repeat (20) @(posedge ref_clk);
                wr(ADDR_TXDATA, 32'h81, r);
            end
        join
        p = cyc;
        tx_byte(t, d);
        chk("defer gap", 32'h1, 32'(t - p >= 4 * 8));
        chk("tx byte", 32'h81, d);
        repeat (200) @(posedge ref_clk);
        rd(ADDR_STATUS, d, r);
        chk("line idle", 32'h1, 32'(d[ST_LINE_IDLE]));
        wr(ADDR_STATUS, 32'h10F, r);
        rd(ADDR_STATUS, d, r);
        chk("coll cleared", 32'h0, 32'(d[ST_COLL]));
        // Narrow pulse while idle.
        mcd_line_partner_inst.pulse();
        repeat (40) @(posedge ref_clk);
        rd(ADDR_STATUS, d, r);
        chk("idle coll", 32'h1, 32'(d[ST_COLL]));
        chk("idle no tx err", 32'h0, 32'(d[ST_TX_ERR]));
        // Narrow pulse in the high half of the second cell of an own frame, first byte not yet sent.
        wr(ADDR_TXDATA, 32'hFF, r);
        do @(negedge ref_clk); while (serial_transmit_pin !== 1'b0);
        repeat (11) @(negedge ref_clk);
        @(posedge ref_clk);
        mcd_line_partner_inst.pulse();
        repeat (600) @(posedge ref_clk);
        rd(ADDR_STATUS, d, r);
        chk("tx err", 32'h0, 32'(d[ST_TX_ERR]));
        chk("coll count", 32'h1, 32'(d[ST_CNT_LO+:4]));
        rd(ADDR_CTRL, d, r);
        chk("tx enable", 32'h1, 32'(d[CTRL_TX_EN]));
        report_and_stop();
    end
endmodule // mcd_line_tb
